//--- verilog/shs_pkg.sv
// Purpose: shared constants and types of the status and counter bank
// Assumes: 32-bit register words, 32-word data buffer
// Notes: offsets are byte addresses on the plain register port
package shs_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BCOUNT_W = 25;
    localparam int WCOUNT_W = 24;
    localparam int STAT_W = 23;
    localparam int TMR_W = 32;
    localparam int BUFW_W = 6;
    localparam int RESP_W = 7;

    // register map
    localparam logic [ADDR_W-1:0] OFS_BCOUNT = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_WCOUNT = 8'h10;

    // flag positions
    localparam int B_RSP_CRC = 0;
    localparam int B_DT_CRC = 1;
    localparam int B_RSP_TO = 2;
    localparam int B_DT_TO = 3;
    localparam int B_TX_UNDR = 4;
    localparam int B_RX_OVR = 5;
    localparam int B_RSP_OK = 6;
    localparam int B_CMD_SENT = 7;
    localparam int B_DT_END = 8;
    localparam int B_SBIT = 9;
    localparam int B_BLK_OK = 10;
    localparam int B_CMD_ACT = 11;
    localparam int B_TXING = 12;
    localparam int B_RXING = 13;
    localparam int B_TX_HALF = 14;
    localparam int B_RX_HALF = 15;
    localparam int B_TX_FULL = 16;
    localparam int B_RX_FULL = 17;
    localparam int B_TX_EMPTY = 18;
    localparam int B_RX_EMPTY = 19;
    localparam int B_TX_AVAIL = 20;
    localparam int B_RX_AVAIL = 21;
    localparam int B_CARD_IRQ = 22;
    localparam logic [STAT_W-1:0] STATIC_MASK = 23'h4007FF;

    // buffer marks, in words
    localparam logic [BUFW_W-1:0] BUF_DEPTH = 6'h20;
    localparam logic [BUFW_W-1:0] HALF_MARK = 6'h08;
    localparam logic [BUFW_W-1:0] FLOW_MARGIN = 6'h02;

    // response timeout, in card clock periods
    localparam logic [RESP_W-1:0] RESP_TO_PERIODS = 7'h40;
    localparam logic [BCOUNT_W-1:0] BCOUNT_ONE = 25'h0000001;
    localparam logic [BCOUNT_W-1:0] BYTE_ROUND = 25'h0000003;

    typedef enum logic [2:0] {
        SHS_IDLE = 3'h0,
        SHS_WAIT_S = 3'h1,
        SHS_XFER_S = 3'h2,
        SHS_BUSY = 3'h3,
        SHS_WAIT_R = 3'h4,
        SHS_XFER_R = 3'h5,
        SHS_RD_WAIT = 3'h6
    } shs_dchan_t;

    // bytes to words, a partial last word counts whole
    function automatic logic [WCOUNT_W-1:0] shs_words_of(input logic [BCOUNT_W-1:0] len);
        logic [BCOUNT_W:0] sum;
        sum = {1'b0, len} + {1'b0, BYTE_ROUND};
        return sum[BCOUNT_W:2];
    endfunction

endpackage

//--- verilog/shs_tmr_if.sv
// Purpose: link between the register bank and its card clock timers
// Assumes: both ends on ref_clk
// Notes: expire strobes are one-cycle pulses
`timescale 1ns/1ps
interface shs_tmr_if;
    logic load;
    logic run;
    logic [31:0] dt_value;
    logic resp_wait;
    logic dt_expire;
    logic resp_expire;
    modport bank (output load, output run, output dt_value, output resp_wait,
                  input dt_expire, input resp_expire);
    modport tmr (input load, input run, input dt_value, input resp_wait,
                 output dt_expire, output resp_expire);
endinterface

//--- verilog/shs_link_timer.sv
// Purpose: data and response timeouts counted in card clock periods
// Assumes: card_clk is asynchronous to ref_clk and much slower
// Notes: card clock is sampled, its rising edges step both counters
`timescale 1ns/1ps
module shs_link_timer
    import shs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // card clock pin
    input wire logic card_clk,
    // bank side
    shs_tmr_if.tmr t
);
    import shs_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [TMR_W-1:0] dcount;
        logic dfired;
        logic dexp;
        logic [RESP_W-1:0] rcount;
        logic rfired;
        logic rexp;
    } shs_tmr_t;

    localparam logic [RESP_W-1:0] RESP_LAST = RESP_TO_PERIODS - 7'h01;

    shs_tmr_t r;
    shs_tmr_t n;
    logic edge_w;

    // s1 feeds s2 only
    assign edge_w = r.s2 && !r.s3;

    always_comb begin
        n = r;
        n.s1 = card_clk;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.dexp = 1'b0;
        n.rexp = 1'b0;
        if (t.load) begin
            n.dcount = t.dt_value;
            n.dfired = 1'b0;
        end else if (t.run && edge_w && !r.dfired) begin
            if (r.dcount == '0) begin
                n.dexp = 1'b1;
                n.dfired = 1'b1;
            end else begin
                n.dcount = r.dcount - 32'h00000001;
            end
        end
        if (!t.resp_wait) begin
            n.rcount = '0;
            n.rfired = 1'b0;
        end else if (edge_w && !r.rfired) begin
            if (r.rcount == RESP_LAST) begin
                n.rexp = 1'b1;
                n.rfired = 1'b1;
            end else begin
                n.rcount = r.rcount + 7'h01;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r <= '0;
        end else if (clk_en) begin
            r <= n;
        end
    end

    assign t.dt_expire = r.dexp;
    assign t.resp_expire = r.rexp;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n || !clk_en);

    AST_RESP_TO: assert property (
        (r.rcount == RESP_LAST && edge_w && t.resp_wait && !r.rfired) |=> t.resp_expire)
        else $error("response timeout not flagged after 64 card clocks");
    AST_DT_TO: assert property (
        (t.run && !t.load && edge_w && r.dcount == '0 && !r.dfired) |=> t.dt_expire)
        else $error("data timeout not flagged at zero");
    AST_DT_ONCE: assert property (
        t.dt_expire |=> !t.dt_expire [*2])
        else $error("data timeout fired twice");
    CV_RESP_TO: cover property (t.resp_expire);

endmodule

//--- verilog/shs_status_counters.sv
// Purpose: status flags, flag clear, interrupt mask, byte and word counters
// Assumes: event and control inputs come from logic on ref_clk
// Notes: card_clk only is asynchronous and is handled in the timer
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module shs_status_counters
    import shs_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // register port
    input wire logic [shs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [shs_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [shs_pkg::DATA_W-1:0] reg_rdata,
    // data setup from the data control logic
    input wire logic [shs_pkg::BCOUNT_W-1:0] data_length_value,
    input wire logic [shs_pkg::TMR_W-1:0] data_timeout_value,
    input wire logic dtctrl_wr,
    input wire logic transfer_enable_bit,
    input wire logic direction_bit,
    input wire logic read_wait_start,
    input wire logic flow_ctrl_en,
    // card engine progress
    input wire logic card_clk,
    input wire logic data_start,
    input wire logic byte_done,
    input wire logic word_done,
    input wire logic card_busy,
    input wire logic cmd_active,
    input wire logic cmd_wait_resp,
    input wire logic [shs_pkg::BUFW_W-1:0] buf_words,
    // card engine events, one-cycle pulses
    input wire logic ev_card_irq,
    input wire logic ev_block_ok,
    input wire logic ev_block_crc_fail,
    input wire logic ev_cmd_sent,
    input wire logic ev_resp_ok,
    input wire logic ev_resp_crc_fail,
    input wire logic ev_start_bit_err,
    input wire logic ev_rx_overrun,
    input wire logic ev_tx_underrun,
    // interrupt
    output logic irq
);
    import shs_pkg::*;

    typedef struct packed {
        shs_dchan_t fsm;
        logic dir;
        logic [BCOUNT_W-1:0] bcount;
        logic [WCOUNT_W-1:0] wcount;
        logic [STAT_W-1:0] stat;
        logic [STAT_W-1:0] mask;
        logic irq;
        logic [DATA_W-1:0] rdata;
    } shs_bank_t;

    shs_bank_t r;
    shs_bank_t n;
    logic start_w;
    logic end_w;
    logic dt_to_w;
    logic [STAT_W-1:0] live_v;
    logic [STAT_W-1:0] set_v;
    logic [STAT_W-1:0] clr_v;
    logic [STAT_W-1:0] flags_v;

    shs_tmr_if tif();

    shs_link_timer u_tmr (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .card_clk(card_clk),
        .t(tif.tmr)
    );

    ////////////////////////////////////////////////////////////////
    // live flags

    assign start_w = dtctrl_wr && transfer_enable_bit;

    // buffer flags follow the active direction only
    always_comb begin
        live_v = '0;
        live_v[B_RX_AVAIL] = r.dir && (buf_words != '0);
        live_v[B_TX_AVAIL] = !r.dir && (buf_words != '0);
        live_v[B_RX_EMPTY] = r.dir && (buf_words == '0);
        live_v[B_TX_EMPTY] = !r.dir && (flow_ctrl_en ?
            (buf_words <= FLOW_MARGIN) : (buf_words == '0));
        live_v[B_RX_FULL] = r.dir && (flow_ctrl_en ?
            (buf_words >= BUF_DEPTH - FLOW_MARGIN) : (buf_words == BUF_DEPTH));
        live_v[B_TX_FULL] = !r.dir && (buf_words == BUF_DEPTH);
        live_v[B_RX_HALF] = r.dir && (buf_words >= HALF_MARK);
        live_v[B_TX_HALF] = !r.dir && (BUF_DEPTH - buf_words >= HALF_MARK);
        live_v[B_RXING] = (r.fsm == SHS_XFER_R);
        live_v[B_TXING] = (r.fsm == SHS_XFER_S) || (r.fsm == SHS_BUSY);
        live_v[B_CMD_ACT] = cmd_active;
    end

    // dynamic bits are never stored, so never cleared
    assign flags_v = r.stat | (live_v & ~STATIC_MASK);

    ////////////////////////////////////////////////////////////////
    // timer hand-off

    assign tif.dt_value = data_timeout_value;
    assign tif.run = (r.fsm == SHS_WAIT_R) || (r.fsm == SHS_BUSY);
    assign tif.load = ((n.fsm == SHS_WAIT_R) || (n.fsm == SHS_BUSY)) && !tif.run;
    assign tif.resp_wait = cmd_wait_resp;

    ////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        n = r;
        end_w = 1'b0;
        dt_to_w = 1'b0;
        set_v = '0;
        clr_v = '0;
        case (r.fsm)
            SHS_IDLE: begin
                if (start_w) begin
                    n.dir = direction_bit;
                    n.bcount = data_length_value;
                    n.wcount = shs_words_of(data_length_value);
                    if (read_wait_start) begin
                        n.fsm = SHS_RD_WAIT;
                    end else if (direction_bit) begin
                        n.fsm = SHS_WAIT_R;
                    end else begin
                        n.fsm = SHS_WAIT_S;
                    end
                end
            end
            SHS_WAIT_S: begin
                if (data_start) begin
                    n.fsm = SHS_XFER_S;
                end
            end
            SHS_WAIT_R: begin
                if (tif.dt_expire) begin
                    dt_to_w = 1'b1;
                    n.fsm = SHS_IDLE;
                end else if (data_start) begin
                    n.fsm = SHS_XFER_R;
                end
            end
            SHS_RD_WAIT: begin
                if (!read_wait_start) begin
                    n.fsm = SHS_WAIT_R;
                end
            end
            SHS_BUSY: begin
                if (tif.dt_expire) begin
                    dt_to_w = 1'b1;
                    n.fsm = SHS_IDLE;
                end else if (!card_busy) begin
                    n.fsm = SHS_XFER_S;
                end
            end
            SHS_XFER_S, SHS_XFER_R: begin
                if (r.bcount == '0) begin
                    end_w = 1'b1;
                end else if (byte_done) begin
                    n.bcount = r.bcount - BCOUNT_ONE;
                    end_w = (r.bcount == BCOUNT_ONE);
                end
                if (end_w) begin
                    n.fsm = SHS_IDLE;
                end else if (r.fsm == SHS_XFER_S && card_busy) begin
                    n.fsm = SHS_BUSY;
                end
            end
            default: begin
                n.fsm = SHS_IDLE;
            end
        endcase
        // clearing transfer enable mid-transfer aborts it
        if (dtctrl_wr && !transfer_enable_bit) begin
            n.fsm = SHS_IDLE;
        end
        if (word_done && r.wcount != '0 && r.fsm != SHS_IDLE) begin
            n.wcount = r.wcount - 24'h000001;
        end

        // sticky flags
        set_v[B_CARD_IRQ] = ev_card_irq;
        set_v[B_BLK_OK] = ev_block_ok;
        set_v[B_CMD_SENT] = ev_cmd_sent;
        set_v[B_RSP_OK] = ev_resp_ok;
        set_v[B_DT_CRC] = ev_block_crc_fail;
        set_v[B_RSP_CRC] = ev_resp_crc_fail;
        set_v[B_SBIT] = ev_start_bit_err;
        set_v[B_RX_OVR] = ev_rx_overrun;
        set_v[B_TX_UNDR] = ev_tx_underrun;
        set_v[B_RSP_TO] = tif.resp_expire;
        set_v[B_DT_TO] = dt_to_w;
        set_v[B_DT_END] = end_w;
        if (reg_wr && reg_addr == OFS_CLEAR) begin
            clr_v = reg_wdata[STAT_W-1:0] & STATIC_MASK;
        end
        // a set in the clearing cycle survives
        n.stat = ((r.stat & ~clr_v) | set_v) & STATIC_MASK;

        if (reg_wr && reg_addr == OFS_MASK) begin
            n.mask = reg_wdata[STAT_W-1:0];
        end
        n.irq = |(flags_v & r.mask);

        // read answer stands one cycle only
        n.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFS_BCOUNT: n.rdata = {7'h00, r.bcount};
                OFS_FLAGS: n.rdata = {9'h000, flags_v};
                OFS_MASK: n.rdata = {9'h000, r.mask};
                OFS_WCOUNT: n.rdata = {8'h00, r.wcount};
                default: n.rdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r <= '0;
        end else if (clk_en) begin
            r <= n;
        end
    end

    assign reg_rdata = r.rdata;
    assign irq = r.irq;

    ////////////////////////////////////////////////////////////////
    // checks

    logic [WCOUNT_W-1:0] words_exp;
    logic rx_half_exp;
    logic irq_exp;
    logic clr_blk;

    assign words_exp = shs_words_of(data_length_value);
    assign rx_half_exp = r.dir && (buf_words >= HALF_MARK);
    assign irq_exp = |(flags_v & r.mask);
    assign clr_blk = reg_wr && reg_addr == OFS_CLEAR && reg_wdata[B_BLK_OK];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n || !clk_en);

    AST_LOAD_BYTES: assert property (
        (r.fsm == SHS_IDLE && start_w && !read_wait_start)
        |=> (r.bcount == $past(data_length_value)) && (r.fsm != SHS_IDLE))
        else $error("byte counter not loaded on leaving idle");
    AST_DATA_END: assert property (
        ((r.fsm == SHS_XFER_S || r.fsm == SHS_XFER_R) && byte_done
         && r.bcount == BCOUNT_ONE && !dtctrl_wr)
        |=> (r.fsm == SHS_IDLE) && r.stat[B_DT_END])
        else $error("last byte did not end the transfer");
    AST_BCOUNT_RO: assert property (
        (reg_wr && reg_addr == OFS_BCOUNT && r.fsm == SHS_IDLE && !start_w)
        |=> $stable(r.bcount))
        else $error("write changed the byte counter");
    AST_STICKY: assert property (
        (r.stat[B_BLK_OK] && !clr_blk) |=> r.stat[B_BLK_OK])
        else $error("static flag dropped without a clear");
    AST_CLEAR: assert property (
        (reg_wr && reg_addr == OFS_CLEAR && reg_wdata[B_RSP_CRC] && !ev_resp_crc_fail)
        |=> !r.stat[B_RSP_CRC])
        else $error("clear write did not clear the flag");
    AST_SET_WINS: assert property (
        ev_card_irq |=> r.stat[B_CARD_IRQ] ##1 (r.stat[B_CARD_IRQ] || $past(reg_wr)))
        else $error("card interrupt flag lost");
    AST_IRQ: assert property (
        1'b1 |=> (irq == $past(irq_exp)))
        else $error("interrupt does not follow enabled flags");
    AST_WORDS: assert property (
        (r.fsm == SHS_IDLE && start_w) |=> (r.wcount == $past(words_exp)))
        else $error("word counter load wrong");
    AST_RD_WAIT: assert property (
        (r.fsm == SHS_IDLE && start_w && read_wait_start) |=> (r.fsm == SHS_RD_WAIT))
        else $error("read wait not entered");
    AST_HALF_READ: assert property (
        (reg_rd && reg_addr == OFS_FLAGS) |=> (reg_rdata[B_RX_HALF] == $past(rx_half_exp)))
        else $error("receive half full flag wrong");
    AST_ABORT: assert property (
        (dtctrl_wr && !transfer_enable_bit) |=> (r.fsm == SHS_IDLE))
        else $error("transfer not aborted");
    AST_RD_ONCE: assert property (
        !reg_rd |=> (reg_rdata == '0))
        else $error("read data stood too long");
    AST_CLR_READ: assert property (
        (reg_rd && reg_addr == OFS_CLEAR) |=> (reg_rdata == '0))
        else $error("flag clear register read not zero");
    AST_DYN_LIVE: assert property (
        (r.stat & ~STATIC_MASK) == '0)
        else $error("dynamic flag latched");
    AST_RXING: assert property (
        (reg_rd && reg_addr == OFS_FLAGS && r.fsm == SHS_XFER_R) |=> reg_rdata[B_RXING])
        else $error("receive in progress not shown");
    AST_ROUND: assert property (
        (r.fsm == SHS_IDLE && start_w)
        |=> ({r.wcount, 2'b00} - {1'b0, $past(data_length_value)} <= {1'b0, BYTE_ROUND}))
        else $error("partial word not rounded up");
    AST_TX_FLOW: assert property (
        (!r.dir && flow_ctrl_en && buf_words == FLOW_MARGIN) |-> flags_v[B_TX_EMPTY])
        else $error("transmit empty not shown at two words");
    AST_RX_FLOW: assert property (
        (r.dir && flow_ctrl_en && buf_words == BUF_DEPTH - FLOW_MARGIN) |-> flags_v[B_RX_FULL])
        else $error("receive full not shown two words early");

    CV_DATA_END: cover property (end_w);
    CV_DT_TO: cover property (dt_to_w);
    CV_RD_WAIT: cover property (r.fsm == SHS_RD_WAIT ##1 r.fsm == SHS_WAIT_R);
    CV_IRQ: cover property (!irq ##1 irq);

endmodule

//--- bench/shs_card_model.sv
// Purpose: card side stand-in that makes the card bus clock
// Assumes: frames are marked by run from the bench
// Notes: clock rests low between frames, never free running
`timescale 1ns/1ps
module shs_card_model (
    // frame control
    input wire logic run,
    // card bus clock
    output logic card_clk
);
    initial begin
        card_clk = 1'b0;
        forever begin
            wait (run);
            // odd offset keeps the phase unrelated to ref_clk
            #37;
            while (run) begin
                card_clk = 1'b1;
                #80;
                card_clk = 1'b0;
                #80;
            end
        end
    end
endmodule

//--- bench/shs_status_counters_test.sv
// Purpose: self-checking bench of the status and counter bank
// Assumes: card model makes the link clock only within frames
// Notes: expected values come from integer arithmetic in this file
`timescale 1ns/1ps
module shs_status_counters_test;
    import shs_pkg::*;
    logic ref_clk, rst_n, reg_wr, reg_rd, dtctrl_wr, dir, rws, flow;
    logic cmd_active, cmd_wait, run, card_clk, irq, ce, tfr, busy;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, d, m;
    logic [BCOUNT_W-1:0] len;
    logic [TMR_W-1:0] tmo;
    logic [BUFW_W-1:0] bw;
    logic [11:0] sig;
    int err_total, comparisons, edges, ln, wn;
    int ev_pos[9] = '{22, 10, 1, 7, 6, 0, 9, 5, 4};
    int ofs[6] = '{0, 4, 8, 12, 16, 20};

    shs_status_counters uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(ce),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata), .data_length_value(len), .data_timeout_value(tmo),
        .dtctrl_wr(dtctrl_wr), .transfer_enable_bit(tfr), .direction_bit(dir),
        .read_wait_start(rws), .flow_ctrl_en(flow), .card_clk(card_clk),
        .data_start(sig[11]), .word_done(sig[10]), .byte_done(sig[9]),
        .card_busy(busy), .cmd_active(cmd_active), .cmd_wait_resp(cmd_wait),
        .buf_words(bw), .ev_card_irq(sig[0]), .ev_block_ok(sig[1]),
        .ev_block_crc_fail(sig[2]), .ev_cmd_sent(sig[3]), .ev_resp_ok(sig[4]),
        .ev_resp_crc_fail(sig[5]), .ev_start_bit_err(sig[6]),
        .ev_rx_overrun(sig[7]), .ev_tx_underrun(sig[8]), .irq(irq));

    shs_card_model card (.run(run), .card_clk(card_clk));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge card_clk) edges++;

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic pl(input logic [11:0] v, input int n);
        @(posedge ref_clk);
        sig <= v;
        repeat (n) @(posedge ref_clk);
        sig <= '0;
    endtask

    task automatic start(input logic rx, input logic rw);
        @(posedge ref_clk);
        len <= 25'(ln);
        dir <= rx;
        rws <= rw;
        dtctrl_wr <= 1'b1;
        @(posedge ref_clk);
        dtctrl_wr <= 1'b0;
    endtask

    // bounded poll; a flag that never rises ends the run
    task automatic poll(input int b, input int lim);
        int n;
        n = 0;
        d = '0;
        while (d[b] !== 1'b1 && n < lim) begin
            rd(OFS_FLAGS);
            n++;
        end
        if (d[b] !== 1'b1) begin
            err_total++;
            $display("unexpected at %0t: flag %0d never rose", $time, b);
            end_of_test();
        end
    endtask

    // live flags 21..12, only the direction of the last start shows
    function automatic logic [9:0] bufexp(input int w, input logic rx, input logic fc);
        logic [3:0] f;
        if (rx) f = {w > 0, w == 0, fc ? w >= 30 : w == 32, w >= 8};
        else f = {w > 0, fc ? w <= 2 : w == 0, w == 32, 32 - w >= 8};
        if (rx) return {f[3], 1'b0, f[2], 1'b0, f[1], 1'b0, f[0], 3'b000};
        return {1'b0, f[3], 1'b0, f[2], 1'b0, f[1], 1'b0, f[0], 2'b00};
    endfunction

    task automatic bufchk(input logic rx);
        int ws[10] = '{0, 2, 3, 7, 8, 24, 25, 29, 30, 32};
        for (int fc = 0; fc < 2; fc++) begin
            foreach (ws[i]) begin
                @(posedge ref_clk);
                bw <= 6'(ws[i]);
                flow <= fc[0];
                rd(OFS_FLAGS);
                chk(32'(d[21:12]), 32'(bufexp(ws[i], rx, fc[0])), "buffer flags");
            end
        end
        $display("test buffer flags dir %0d done", rx);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, reg_wr, reg_rd, dtctrl_wr, dir, rws, flow, cmd_active, cmd_wait} = '0;
        {addr, wdata, len, tmo, bw, sig, run} = '0;
        {ce, tfr, busy} = 3'b110;
        void'($urandom(32'h074e));
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        foreach (ofs[i]) begin
            rd(8'(ofs[i]));
            // an empty transmit buffer shows live even right after reset
            chk(d, (ofs[i] == 4) ? 32'(bufexp(0, 1'b0, 1'b0)) << 12 : 32'h0, "reset value");
        end
        $display("test reset done");
        m = $urandom;
        wr(OFS_MASK, m);
        rd(OFS_MASK);
        chk(d, m & 32'h007FFFFF, "mask readback");
        wr(OFS_MASK, 32'h0);
        for (int i = 0; i < 9; i++) begin
            pl(12'h001 << i, 1);
            wr(OFS_CLEAR, ~(32'h1 << ev_pos[i]));
            rd(OFS_FLAGS);
            chk(d & 32'(STATIC_MASK), 32'h1 << ev_pos[i], "event flag");
            chk(32'(irq), 32'h0, "masked irq");
            wr(OFS_MASK, 32'h1 << ev_pos[i]);
            repeat (2) @(posedge ref_clk);
            #1 chk(32'(irq), 32'h1, "enabled irq");
            wr(OFS_CLEAR, 32'h1 << ev_pos[i]);
            rd(OFS_FLAGS);
            chk(d & 32'(STATIC_MASK), 32'h0, "flag clear");
            chk(32'(irq), 32'h0, "irq after clear");
            wr(OFS_MASK, 32'h0);
        end
        $display("test events done");
        for (int k = 0; k < 2; k++) begin
            ln = (k == 0) ? $urandom_range(9, 1) : 8;
            wn = (ln + 3) / 4;
            start(1'b0, 1'b0);
            rd(OFS_BCOUNT);
            chk(d, 32'(ln), "byte count load");
            rd(OFS_WCOUNT);
            chk(d, 32'(wn), "word count load");
            pl(12'h400, 1);
            rd(OFS_WCOUNT);
            chk(d, 32'(wn - 1), "word count step");
            pl(12'h800, 1);
            rd(OFS_FLAGS);
            chk(32'(d[12]), 32'h1, "transmitting");
            busy <= 1'b1;
            rd(OFS_FLAGS);
            busy <= 1'b0;
            chk(32'(d[12]), 32'h1, "busy still transmitting");
            pl(12'h200, ln);
            rd(OFS_FLAGS);
            chk(32'({d[12], d[8]}), 32'h1, "data end");
            rd(OFS_BCOUNT);
            chk(d, 32'h0, "byte count end");
            wr(OFS_BCOUNT, $urandom);
            rd(OFS_BCOUNT);
            chk(d, 32'h0, "byte count write");
            wr(OFS_CLEAR, 32'h100);
        end
        $display("test send transfer done");
        bufchk(1'b0);
        @(posedge ref_clk);
        cmd_active <= 1'b1;
        rd(OFS_FLAGS);
        chk(32'(d[11]), 32'h1, "command active");
        cmd_active <= 1'b0;
        tmo <= 32'h3;
        ln = 16;
        start(1'b1, 1'b1);
        run <= 1'b1;
        repeat (96) @(posedge ref_clk);
        // no card edge may be in flight when the timer loads
        run <= 1'b0;
        rd(OFS_FLAGS);
        chk(32'(d[3]), 32'h0, "no timeout in read wait");
        repeat (12) @(posedge ref_clk);
        rws <= 1'b0;
        edges = 0;
        @(posedge ref_clk);
        run <= 1'b1;
        poll(3, 200);
        chk(32'(edges >= 4 && edges <= 5), 32'h1, "data timeout edges");
        run <= 1'b0;
        wr(OFS_CLEAR, 32'h8);
        $display("test data timeout done");
        bufchk(1'b1);
        @(posedge ref_clk);
        cmd_wait <= 1'b1;
        run <= 1'b1;
        edges = 0;
        poll(2, 400);
        chk(32'(edges >= 64 && edges <= 65), 32'h1, "response timeout edges");
        run <= 1'b0;
        cmd_wait <= 1'b0;
        $display("test response timeout done");
        ln = 12;
        start(1'b1, 1'b0);
        pl(12'h800, 1);
        rd(OFS_FLAGS);
        chk(32'({d[13], d[12]}), 32'h2, "receiving");
        @(posedge ref_clk);
        tfr <= 1'b0;
        dtctrl_wr <= 1'b1;
        @(posedge ref_clk);
        dtctrl_wr <= 1'b0;
        tfr <= 1'b1;
        rd(OFS_FLAGS);
        chk(32'({d[13], d[8]}), 32'h0, "abort to idle");
        ce <= 1'b0;
        pl(12'h001, 1);
        ce <= 1'b1;
        rd(OFS_FLAGS);
        chk(32'(d[22]), 32'h0, "event while disabled");
        $display("test abort and freeze done");
        end_of_test();
    end
endmodule
